// ---- hw/iew_pkg.sv ----
// package: constants, register map and carrier types of the interrupt entry and wake logic
package iew_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          NUM_PER_REGS    = 4;

  // register byte offsets
  localparam logic [11:0] OFF_CONTROL     = 12'h000;
  localparam logic [11:0] OFF_CORE_EN     = 12'h004;
  localparam logic [11:0] OFF_CORE_FLAG   = 12'h008;
  localparam logic [11:0] OFF_PER_EN0     = 12'h00C;
  localparam logic [11:0] OFF_PER_FLAG0   = 12'h01C;
  localparam int          SHADOW_BANK     = 31;
  localparam logic [11:0] OFF_SHADOW_BASE = 12'h7C0;
  localparam logic [11:0] OFF_SH_ACC      = 12'h7C0;
  localparam logic [11:0] OFF_SH_STATUS   = 12'h7C4;
  localparam logic [11:0] OFF_SH_BANK     = 12'h7C8;
  localparam logic [11:0] OFF_SH_FSR0     = 12'h7CC;
  localparam logic [11:0] OFF_SH_FSR1     = 12'h7D0;
  localparam logic [11:0] OFF_SH_PCUPPER  = 12'h7D4;

  // control register fields
  localparam int          BIT_GIE         = 7;
  localparam int          BIT_PERIPHERAL_GROUP_ENABLE        = 6;
  localparam int          BIT_EDGE        = 0;
  localparam logic        EDGE_RESET      = 1'b1;

  // core source bit positions
  localparam int          BIT_TMR0        = 5;
  localparam int          BIT_IOC         = 4;
  localparam int          BIT_EXT         = 0;
  localparam logic [7:0]  CORE_MASK       = 8'h31;

  // status bits that the shadow copy keeps: watchdog expired (4) and sleep entered (3)
  localparam logic [7:0]  STATUS_KEEP     = 8'h18;

  localparam logic [15:0] IRQ_VECTOR      = 16'h0004;
  localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  status;
    logic [7:0]  bank_select;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [7:0]  pc_upper_latch;
  } iew_ctx_t;

  typedef struct packed {
    logic        flush;
    logic        push;
    logic        load_vector;
    logic [15:0] vector;
  } iew_entry_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } iew_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } iew_apb_rsp_t;

endpackage : iew_pkg

// ---- hw/iew_irq_ctrl.sv ----
// interrupt entry, shadow context and wake-from-sleep controller with apb register access
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module iew_irq_ctrl #(
  parameter int NUM_PER_REGS = iew_pkg::NUM_PER_REGS
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // register bus
  input  wire iew_pkg::iew_apb_req_t apb_req,
  output var  iew_pkg::iew_apb_rsp_t apb_rsp,
  // core sequencer
  input  wire logic                  first_clock_phase,
  input  wire logic                  core_sleeping,
  input  wire logic                  instr_retired,
  input  wire logic                  return_from_service_instr,
  input  wire iew_pkg::iew_ctx_t     live_ctx,
  output var  iew_pkg::iew_entry_t   entry,
  output var  logic                  irq_request,
  output var  logic                  wake_request,
  output var  logic                  restore_valid,
  output var  iew_pkg::iew_ctx_t     restore_ctx,
  output var  logic                  global_irq_enable,
  // event sources
  input  wire logic                  tmr0_event,
  input  wire logic                  ioc_event,
  input  wire logic [31:0]           periph_events,
  input  wire logic                  ext_irq_pin
);
  import iew_pkg::*;

  if (NUM_PER_REGS != 4) begin : g_bad_count
    $error("iew_irq_ctrl: exactly four peripheral flag registers are supported");
  end

  typedef enum logic [0:0] {ST_RUN, ST_WAKE_HOLD} iew_state_t;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // state
  logic                   gie_reg;
  logic                   peripheral_group_enable_reg;
  logic                   edge_sel_reg;
  logic [7:0]             core_en_reg;
  logic [7:0]             core_flag_reg;
  logic [3:0][7:0]        per_en_reg;
  logic [3:0][7:0]        per_flag_reg;
  logic                   ext_prev_reg;
  iew_ctx_t               shadow_reg;
  iew_state_t             state_reg;
  iew_state_t             state_next;
  iew_apb_rsp_t           rsp_reg;
  iew_entry_t             entry_reg;
  logic                   irq_req_reg;
  logic                   wake_reg;
  logic                   restore_reg;
  iew_ctx_t               restore_ctx_reg;

  // bus decode
  wire logic [11:0]       addr     = apb_req.paddr;
  wire logic              access   = apb_req.psel & apb_req.penable;
  wire logic              done     = access & rsp_reg.pready;
  wire logic              wr       = done & apb_req.pwrite;
  wire logic [31:0]       wd       = apb_req.pwdata;
  wire logic              wr_ctl   = wr & hit(addr, OFF_CONTROL);
  wire logic              wr_cen   = wr & hit(addr, OFF_CORE_EN);
  wire logic              wr_cflg  = wr & hit(addr, OFF_CORE_FLAG);
  wire logic              wr_acc   = wr & hit(addr, OFF_SH_ACC);
  wire logic              wr_stat  = wr & hit(addr, OFF_SH_STATUS);
  wire logic              wr_bank  = wr & hit(addr, OFF_SH_BANK);
  wire logic              wr_fsr0  = wr & hit(addr, OFF_SH_FSR0);
  wire logic              wr_fsr1  = wr & hit(addr, OFF_SH_FSR1);
  wire logic              wr_pcu   = wr & hit(addr, OFF_SH_PCUPPER);
  wire logic [11:0]       per_en_off   = addr - OFF_PER_EN0;
  wire logic [11:0]       per_flag_off = addr - OFF_PER_FLAG0;
  wire logic              in_per_en    = (addr >= OFF_PER_EN0) && (addr < OFF_PER_FLAG0) && (addr[1:0] == 2'b00);
  wire logic              in_per_flag  = (addr >= OFF_PER_FLAG0) && (per_flag_off < 12'h010) && (addr[1:0] == 2'b00);
  wire logic [1:0]        per_en_idx   = per_en_off[3:2];
  wire logic [1:0]        per_flag_idx = per_flag_off[3:2];

  // external pin edge, polarity chosen by the select bit
  wire logic              rise     = ext_irq_pin & ~ext_prev_reg;
  wire logic              fall     = ~ext_irq_pin & ext_prev_reg;
  wire logic              ext_edge = edge_sel_reg ? rise : fall;

  wire logic [7:0]        core_evt = (8'(tmr0_event) << BIT_TMR0) | (8'(ioc_event) << BIT_IOC)
                                   | (8'(ext_edge) << BIT_EXT);

  // pending terms
  wire logic              core_pend = |(core_flag_reg & core_en_reg & CORE_MASK);
  wire logic              per_pend  = |(per_flag_reg & per_en_reg);
  wire logic              any_pend  = core_pend | (peripheral_group_enable_reg & per_pend);
  wire logic              request   = gie_reg & any_pend;
  // a request left pending while the enable was clear is taken at the first sample after it is set
  wire logic              take      = first_clock_phase & request & ~core_sleeping
                                    & (state_reg == ST_RUN);
  // only enabled sources wake; firmware must set enables before sleeping
  wire logic              wake      = core_sleeping & any_pend;

  // register read mux
  logic [31:0]            rd_data;
  logic                   rd_ok;
  always_comb
  begin
    rd_data = RESET_ZERO;
    rd_ok   = 1'b1;
    if (in_per_en)
      rd_data = {24'h000000, per_en_reg[per_en_idx]};
    else if (in_per_flag)
      rd_data = {24'h000000, per_flag_reg[per_flag_idx]};
    else
    begin
      case (addr)
        OFF_CONTROL:    rd_data = {24'h000000, gie_reg, peripheral_group_enable_reg, 5'h00, edge_sel_reg};
        OFF_CORE_EN:    rd_data = {24'h000000, core_en_reg};
        OFF_CORE_FLAG:  rd_data = {24'h000000, core_flag_reg};
        OFF_SH_ACC:     rd_data = {24'h000000, shadow_reg.acc};
        OFF_SH_STATUS:  rd_data = {24'h000000, shadow_reg.status};
        OFF_SH_BANK:    rd_data = {24'h000000, shadow_reg.bank_select};
        OFF_SH_FSR0:    rd_data = {16'h0000, shadow_reg.fsr0};
        OFF_SH_FSR1:    rd_data = {16'h0000, shadow_reg.fsr1};
        OFF_SH_PCUPPER: rd_data = {24'h000000, shadow_reg.pc_upper_latch};
        default:        rd_ok   = 1'b0;
      endcase
    end
  end

  // one wait state: ready is a flop so the reply never depends on this cycle's address
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rsp_reg <= '0;
    else
    begin
      rsp_reg.pready  <= access & ~rsp_reg.pready;
      rsp_reg.pslverr <= access & ~rsp_reg.pready & ~rd_ok;
      rsp_reg.prdata  <= (access & ~rsp_reg.pready & ~apb_req.pwrite) ? rd_data : RESET_ZERO;
    end
  end

  // control bits; hardware entry and return take priority over a bus write
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      gie_reg      <= 1'b0;
      peripheral_group_enable_reg     <= 1'b0;
      edge_sel_reg <= EDGE_RESET;
      core_en_reg  <= 8'h00;
      per_en_reg   <= '0;
    end
    else
    begin
      if (take)
        gie_reg <= 1'b0;
      else if (return_from_service_instr)
        gie_reg <= 1'b1;
      else if (wr_ctl)
        gie_reg <= wd[BIT_GIE];
      if (wr_ctl)
      begin
        peripheral_group_enable_reg     <= wd[BIT_PERIPHERAL_GROUP_ENABLE];
        edge_sel_reg <= wd[BIT_EDGE];
      end
      if (wr_cen)
        core_en_reg <= wd[7:0] & CORE_MASK;
      if (wr & in_per_en)
        per_en_reg[per_en_idx] <= wd[7:0];
    end
  end

  // flags: firmware writes them, events set them whatever the enables, set wins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      core_flag_reg <= 8'h00;
      per_flag_reg  <= '0;
      ext_prev_reg  <= 1'b0;
    end
    else
    begin
      ext_prev_reg  <= ext_irq_pin;
      core_flag_reg <= ((wr_cflg ? wd[7:0] : core_flag_reg) & CORE_MASK) | core_evt;
      for (int i = 0; i < 4; i++)
        per_flag_reg[i] <= ((wr & in_per_flag & (per_flag_idx == 2'(i))) ? wd[7:0] : per_flag_reg[i])
                         | periph_events[i*8 +: 8];
    end
  end

  // shadow copy; status keeps its watchdog and sleep bits from the old copy
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      shadow_reg <= '0;
    else if (take)
    begin
      shadow_reg        <= live_ctx;
      shadow_reg.status <= (live_ctx.status & ~STATUS_KEEP) | (shadow_reg.status & STATUS_KEEP);
    end
    else
    begin
      if (wr_acc)
        shadow_reg.acc <= wd[7:0];
      if (wr_stat)
        shadow_reg.status <= wd[7:0];
      if (wr_bank)
        shadow_reg.bank_select <= wd[7:0];
      if (wr_fsr0)
        shadow_reg.fsr0 <= wd[15:0];
      if (wr_fsr1)
        shadow_reg.fsr1 <= wd[15:0];
      if (wr_pcu)
        shadow_reg.pc_upper_latch <= wd[7:0];
    end
  end

  // after a wake with the enable set, hold entry until one instruction has retired
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (wake & gie_reg)
          state_next = ST_WAKE_HOLD;
      ST_WAKE_HOLD:
        if (instr_retired & ~core_sleeping)
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg       <= ST_RUN;
      entry_reg       <= '0;
      irq_req_reg     <= 1'b0;
      wake_reg        <= 1'b0;
      restore_reg     <= 1'b0;
      restore_ctx_reg <= '0;
    end
    else
    begin
      state_reg             <= state_next;
      entry_reg.flush       <= take;
      entry_reg.push        <= take;
      entry_reg.load_vector <= take;
      entry_reg.vector      <= take ? IRQ_VECTOR : 16'h0000;
      irq_req_reg           <= request;
      wake_reg              <= wake;
      restore_reg           <= return_from_service_instr;
      if (return_from_service_instr)
        restore_ctx_reg <= shadow_reg;
    end
  end

  assign apb_rsp           = rsp_reg;
  assign entry             = entry_reg;
  assign irq_request       = irq_req_reg;
  assign wake_request      = wake_reg;
  assign restore_valid     = restore_reg;
  assign restore_ctx       = restore_ctx_reg;
  assign global_irq_enable = gie_reg;

endmodule // iew_irq_ctrl

`default_nettype wire

// ---- dv/iew_core_model.sv ----
// core sequencer model: phase strobe, sleep, retire and return pulses
`timescale 1ns/1ps
`default_nettype none

module iew_core_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // bench commands
  input  wire logic sleep_cmd,
  input  wire logic ret_cmd,
  // block side
  input  wire logic wake_request,
  output var  logic first_clock_phase,
  output var  logic core_sleeping,
  output var  logic instr_retired,
  output var  logic return_from_service_instr
);
  logic [1:0] phase_reg;

  // four clocks per instruction cycle; a sleeping core retires nothing
  always_ff @(posedge clock)
  begin
    phase_reg                 <= sys_rst ? 2'h0 : phase_reg + 2'h1;
    first_clock_phase         <= !sys_rst && phase_reg == 2'h3;
    instr_retired             <= !sys_rst && phase_reg == 2'h3 && !core_sleeping;
    core_sleeping             <= !sys_rst && (sleep_cmd || core_sleeping && !wake_request);
    return_from_service_instr <= !sys_rst && ret_cmd;
  end
endmodule // iew_core_model

`default_nettype wire

// ---- dv/iew_irq_ctrl_props.sv ----
// assertions on the interrupt entry and wake controller ports
`timescale 1ns/1ps
`default_nettype none

module iew_irq_ctrl_props (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  sys_rst,
  // watched ports
  input wire iew_pkg::iew_apb_req_t apb_req,
  input wire iew_pkg::iew_apb_rsp_t apb_rsp,
  input wire logic                  first_clock_phase,
  input wire logic                  core_sleeping,
  input wire logic                  return_from_service_instr,
  input wire iew_pkg::iew_entry_t   entry,
  input wire logic                  irq_request,
  input wire logic                  wake_request,
  input wire logic                  restore_valid,
  input wire logic                  global_irq_enable
);
  import iew_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_access; apb_req.psel && apb_req.penable && !apb_rsp.pready; endsequence
  sequence s_answer; apb_rsp.pready ##1 !apb_rsp.pready; endsequence
  property p_rst; $fell(sys_rst) |-> !global_irq_enable && !irq_request; endproperty
  a_rst: assert property (p_rst) else $error("enable or request set after reset");
  property p_vec; entry.load_vector |-> entry.flush && entry.push && entry.vector == IRQ_VECTOR && !global_irq_enable;
  endproperty
  a_vec: assert property (p_vec) else $error("entry pulse malformed");
  property p_take; entry.load_vector |-> $past(first_clock_phase) && $past(global_irq_enable) && !$past(core_sleeping);
  endproperty
  a_take: assert property (p_take) else $error("entry without phase one or enable");
  property p_again; entry.load_vector |=> !entry.load_vector [*3]; endproperty
  a_again: assert property (p_again) else $error("entry repeated while disabled");
  property p_ret; return_from_service_instr |=> restore_valid && (global_irq_enable || entry.load_vector); endproperty
  a_ret: assert property (p_ret) else $error("return did not restore");
  property p_rise; $rose(global_irq_enable) |-> restore_valid || $past(apb_req.pwrite && apb_rsp.pready); endproperty
  a_rise: assert property (p_rise) else $error("enable rose without cause");
  property p_apb; s_access |=> s_answer; endproperty
  a_apb: assert property (p_apb) else $error("bus answer late or long");
  property p_wake; wake_request |-> $past(core_sleeping); endproperty
  a_wake: assert property (p_wake) else $error("wake while running");
endmodule // iew_irq_ctrl_props

bind iew_irq_ctrl iew_irq_ctrl_props u_props (.clock, .sys_rst, .apb_req, .apb_rsp, .first_clock_phase,
  .core_sleeping, .return_from_service_instr, .entry, .irq_request, .wake_request, .restore_valid,
  .global_irq_enable);

`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the interrupt entry and wake controller
`timescale 1ns/1ps
`default_nettype none

module tb;
  import iew_pkg::*;
  logic         clock = 1'b0, sys_rst = 1'b1, ext_irq_pin = 1'b0, ret_ok = 1'b1, err;
  logic         sleep_cmd = 1'b0, ret_cmd = 1'b0, tmr0_event = 1'b0, ioc_event = 1'b0;
  logic         first_clock_phase, core_sleeping, instr_retired, return_from_service_instr;
  logic         irq_request, wake_request, restore_valid, global_irq_enable;
  logic [31:0]  periph_events = 32'h0, rd;
  iew_apb_req_t apb_req = '0;
  iew_apb_rsp_t apb_rsp;
  iew_entry_t   entry;
  iew_ctx_t     restore_ctx, live_ctx = 64'h3CFF_1F12_3456_780A;
  int           fails = 0, checks_done = 0;
  iew_irq_ctrl u_dut (.clock, .sys_rst, .apb_req, .apb_rsp, .first_clock_phase, .core_sleeping, .instr_retired,
    .return_from_service_instr, .live_ctx, .entry, .irq_request, .wake_request, .restore_valid, .restore_ctx,
    .global_irq_enable, .tmr0_event, .ioc_event, .periph_events, .ext_irq_pin);
  iew_core_model u_core (.clock, .sys_rst, .sleep_cmd, .ret_cmd, .wake_request, .first_clock_phase,
    .core_sleeping, .instr_retired, .return_from_service_instr);
  initial
    forever #2 clock = ~clock;
  // cleared on sleep, set once an awake core retires an instruction
  always @(posedge clock)
    ret_ok <= sleep_cmd ? 1'b0 : ret_ok | (instr_retired & !core_sleeping);
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    fails += int'(g !== e);
    if (g !== e)
      $display("mismatch %s expected %h seen %h", nm, e, g);
  endtask
  // on a read the data argument is the expected value
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    for (int n = 0; n < 50 && apb_rsp.pready !== 1'b1; n++)
      @(posedge clock);
    {err, rd} = {apb_rsp.pslverr, apb_rsp.prdata};
    apb_req <= '0;
    if (!w)
      check($sformatf("reg %h", a), d, rd);
  endtask
  // bits: sleep, return, timer, change, then the 32 peripheral events
  task automatic pulse(input logic [35:0] m);
    @(posedge clock);
    {sleep_cmd, ret_cmd, tmr0_event, ioc_event, periph_events} <= m;
    @(posedge clock);
    {sleep_cmd, ret_cmd, tmr0_event, ioc_event, periph_events} <= 36'h0;
  endtask
  task automatic exp_entry(input logic e);
    logic seen = 1'b0;
    logic ok = 1'b1;
    repeat (40)
    begin
      @(negedge clock);
      ok &= !entry.load_vector || ret_ok;
      seen |= entry.load_vector;
    end
    check("entry", {31'h0, e}, {31'h0, seen});
    check("retire", 32'h1, {31'h0, ok});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10000) @(posedge clock);
    fails++;
    test_done;
  end
  initial
  begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, OFF_CONTROL, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    for (int i = 0; i < 4; i++)
    begin
      pulse(36'h1 << (9 * i));
      apb(1'b0, OFF_PER_FLAG0 + 12'(4 * i), 32'h1 << i);
    end
    apb(1'b1, OFF_PER_EN0 + 12'h4, 32'h2);
    apb(1'b1, OFF_CONTROL, 32'h81);
    exp_entry(1'b0);
    apb(1'b1, OFF_CONTROL, 32'hC1);
    exp_entry(1'b1);
    apb(1'b0, OFF_SH_ACC, 32'h3C);
    apb(1'b0, OFF_SH_STATUS, 32'hE7);
    apb(1'b1, OFF_CORE_EN, 32'h20);
    pulse(36'h2_0000_0000);
    exp_entry(1'b0);
    check("request", 32'h0, {31'h0, irq_request});
    apb(1'b0, OFF_CORE_FLAG, 32'h20);
    apb(1'b1, OFF_SH_ACC, 32'h5A);
    apb(1'b1, OFF_PER_FLAG0 + 12'h4, 32'h0);
    pulse(36'h4_0000_0000);
    exp_entry(1'b1);
    check("restored acc", 32'h5A, {24'h0, restore_ctx.acc});
    pulse(36'h4_0000_0000);
    exp_entry(1'b1);
    apb(1'b1, OFF_CORE_FLAG, 32'h0);
    pulse(36'h4_0000_0000);
    exp_entry(1'b0);
    check("gie", 32'h1, {31'h0, global_irq_enable});
    apb(1'b1, OFF_CORE_EN, 32'h1);
    for (int e = 0; e < 2; e++)
    begin
      apb(1'b1, OFF_CONTROL, 32'h40 | 32'(e));
      apb(1'b1, OFF_CORE_FLAG, 32'h0);
      ext_irq_pin <= (e == 0);
      apb(1'b0, OFF_CORE_FLAG, 32'h0);
      ext_irq_pin <= (e == 1);
      apb(1'b0, OFF_CORE_FLAG, 32'h1);
    end
    apb(1'b1, OFF_CONTROL, 32'hC1);
    exp_entry(1'b1);
    apb(1'b1, OFF_CORE_EN, 32'h0);
    apb(1'b1, OFF_CORE_FLAG, 32'h0);
    pulse(36'h8_0000_0000);
    pulse(36'h1_0000_0000);
    exp_entry(1'b0);
    check("asleep", 32'h1, {31'h0, core_sleeping});
    check("no wake", 32'h0, {31'h0, wake_request});
    apb(1'b1, OFF_CORE_FLAG, 32'h0);
    apb(1'b1, OFF_CORE_EN, 32'h10);
    pulse(36'h1_0000_0000);
    exp_entry(1'b0);
    check("awake", 32'h0, {31'h0, core_sleeping});
    apb(1'b1, OFF_CORE_FLAG, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h81);
    pulse(36'h8_0000_0000);
    pulse(36'h1_0000_0000);
    exp_entry(1'b1);
    test_done;
  end
endmodule // tb

`default_nettype wire
